// [hdl/iestk_pkg.sv]
// Shared constants for the interrupt entry and stack unit.
package iestk_pkg;
    localparam int          NUM_SRC           = 8;
    localparam int          SP_W              = 16;
    localparam int          PC_W              = 13;
    localparam logic [15:0] TOP_OF_DATA_MEMORY = 16'h04ff;
    localparam logic [15:0] SP_SAFE_FLOOR     = 16'h0100;
    localparam logic [12:0] BOOT_SECTION_BASE = 13'h1c00;
    localparam logic [12:0] VECTOR_STRIDE     = 13'h0002;
    localparam logic [12:0] RESET_VECTOR      = 13'h0000;
    localparam int          GIE_BIT           = 7;
    localparam int          VECTOR_TABLE_RELOCATE_BIT         = 1;
    localparam int          ENTRY_NS          = 400;
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          ENTRY_CYCLES      = (ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_EXTRA_CYCLES = 4;
    localparam int          EXIT_CYCLES       = 4;
    localparam logic [3:0]  ENTRY_CNT         = 4'(ENTRY_CYCLES);
    localparam logic [3:0]  WAKE_CNT          = 4'(ENTRY_CYCLES + WAKE_EXTRA_CYCLES);
    localparam logic [3:0]  EXIT_CNT          = 4'(EXIT_CYCLES);
    typedef enum logic [3:0] {
        IESTK_OP_NONE,
        IESTK_OP_PUSH,
        IESTK_OP_POP,
        IESTK_OP_CALL,
        IESTK_OP_RET,
        IESTK_OP_IRQ_EXIT_INSTR,
        IESTK_OP_SEI,
        IESTK_OP_CLI
    } iestk_op_e;
endpackage : iestk_pkg

// [hdl/iestk_flags.sv]
// Sticky request flags with set-over-clear priority and acknowledge clearing.
`timescale 1ns/1ps
module iestk_flags
    import iestk_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic [NUM_SRC-1:0] event_in,
    input  wire logic [NUM_SRC-1:0] sw_clear,
    input  wire logic [NUM_SRC-1:0] hw_ack,
    output logic      [NUM_SRC-1:0] flags
);
    genvar g;
    generate
        for (g = 0; g < NUM_SRC; g++) begin : g_flag
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    flags[g] <= 1'b0;
                end else if (event_in[g]) begin
                    flags[g] <= 1'b1;
                end else if (sw_clear[g] || hw_ack[g]) begin
                    flags[g] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule : iestk_flags

// [hdl/iestk_core.sv]
// Interrupt entry/exit sequencing and stack pointer for the CPU core.
`timescale 1ns/1ps
module iestk_core
    import iestk_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic [NUM_SRC-1:0] event_in,
    input  wire logic [NUM_SRC-1:0] level_req,
    input  wire logic [NUM_SRC-1:0] is_level,
    input  wire logic [NUM_SRC-1:0] irq_enable,
    input  wire logic [NUM_SRC-1:0] flag_clear_wr,
    input  wire logic               instr_boundary,
    input  wire logic               sleeping,
    input  wire logic [3:0]         op,
    input  wire logic [PC_W-1:0]    return_pc,
    input  wire logic               sph_wr,
    input  wire logic               spl_wr,
    input  wire logic [7:0]         io_wdata,
    input  wire logic               flags_wr,
    input  wire logic [7:0]         flags_wdata,
    input  wire logic               ctrl_wr,
    input  wire logic [7:0]         ctrl_wdata,
    input  wire logic               boot_vector_fuse,
    input  wire logic [7:0]         mem_rdata,
    output logic      [7:0]         stack_pointer_high,
    output logic      [7:0]         stack_pointer_low,
    output logic      [7:0]         cpu_flags_reg,
    output logic      [7:0]         core_control_reg,
    output logic      [NUM_SRC-1:0] pending_flags,
    output logic      [NUM_SRC-1:0] irq_ack,
    output logic                    seq_stall,
    output logic                    mem_we,
    output logic      [SP_W-1:0]    mem_addr,
    output logic      [7:0]         mem_wdata,
    output logic                    pc_load,
    output logic      [PC_W-1:0]    pc_value,
    output logic      [PC_W-1:0]    reset_vector
);
    typedef enum logic [2:0] {
        IESTK_IDLE,
        IESTK_ENTRY,
        IESTK_EXIT
    } iestk_state_e;

    typedef struct packed {
        iestk_state_e       state;
        logic [3:0]         cnt;
        logic [SP_W-1:0]    sp;
        logic [7:0]         flags;
        logic [7:0]         ctrl;
        logic               hold_one;
        logic [PC_W-1:0]    save_pc;
        logic [PC_W-1:0]    vec;
        logic [PC_W-1:0]    rest_pc;
        logic [NUM_SRC-1:0] ack;
        logic               stall;
        logic               we;
        logic [SP_W-1:0]    addr;
        logic [7:0]         wdata;
        logic               pc_load;
        logic [PC_W-1:0]    pc_value;
        logic [PC_W-1:0]    rst_vec;
    } iestk_st_s;

    iestk_st_s r;
    iestk_st_s next_r;
    logic [NUM_SRC-1:0] sticky;
    logic [NUM_SRC-1:0] request;
    logic               any_req;
    logic [PC_W-1:0]    win_idx;
    logic [PC_W-1:0]    table_base;

    iestk_flags u_flags (
        .clock    (clock),
        .rst_n    (rst_n),
        .event_in (event_in & ~is_level),
        .sw_clear (flag_clear_wr),
        .hw_ack   (r.ack),
        .flags    (sticky)
    );

    // Level sources request straight from their live condition, events from the latch.
    assign request = ((sticky & ~is_level) | (level_req & is_level)) & irq_enable;

    // Priority encode from the top so the lowest index, lowest vector, is kept last.
    always_comb begin
        win_idx = '0;
        any_req = 1'b0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (request[i]) begin
                win_idx = PC_W'(i + 1);
                any_req = 1'b1;
            end
        end
    end

    assign table_base = r.ctrl[VECTOR_TABLE_RELOCATE_BIT] ? BOOT_SECTION_BASE : RESET_VECTOR;

    always_comb begin
        next_r          = r;
        next_r.ack      = '0;
        next_r.we       = 1'b0;
        next_r.pc_load  = 1'b0;
        next_r.rst_vec  = boot_vector_fuse ? BOOT_SECTION_BASE : RESET_VECTOR;
        if (sph_wr) begin
            next_r.sp[15:8] = io_wdata;
        end
        if (spl_wr) begin
            next_r.sp[7:0] = io_wdata;
        end
        // The whole status byte lives here; the sequencer itself only sets and clears the global enable bit.
        if (flags_wr) begin
            next_r.flags = flags_wdata;
        end
        if (ctrl_wr) begin
            next_r.ctrl = ctrl_wdata;
        end
        case (r.state)
            IESTK_IDLE: begin
                next_r.stall = 1'b0;
                if (instr_boundary) begin
                    next_r.hold_one = 1'b0;
                end
                case (iestk_op_e'(op))
                    IESTK_OP_PUSH: next_r.sp = r.sp - 16'h0001;
                    IESTK_OP_POP:  next_r.sp = r.sp + 16'h0001;
                    IESTK_OP_CALL: next_r.sp = r.sp - 16'h0002;
                    IESTK_OP_RET:  next_r.sp = r.sp + 16'h0002;
                    IESTK_OP_SEI: begin
                        next_r.flags[GIE_BIT] = 1'b1;
                        next_r.hold_one       = 1'b1;
                    end
                    IESTK_OP_CLI:  next_r.flags[GIE_BIT] = 1'b0;
                    default: begin
                    end
                endcase
                // Sampling the request only at boundaries lets a multi-cycle op finish.
                if (iestk_op_e'(op) == IESTK_OP_IRQ_EXIT_INSTR) begin
                    next_r.state = IESTK_EXIT;
                    next_r.cnt   = EXIT_CNT;
                    next_r.stall = 1'b1;
                    next_r.we    = 1'b0;
                    next_r.addr  = r.sp + 16'h0001;
                end else if (instr_boundary && any_req && r.flags[GIE_BIT] && !r.hold_one
                             && iestk_op_e'(op) != IESTK_OP_CLI
                             && iestk_op_e'(op) != IESTK_OP_SEI
                             && !flags_wr) begin
                    next_r.state          = IESTK_ENTRY;
                    next_r.cnt            = sleeping ? WAKE_CNT : ENTRY_CNT;
                    next_r.flags[GIE_BIT] = 1'b0;
                    next_r.stall          = 1'b1;
                    next_r.save_pc        = return_pc;
                    next_r.vec            = table_base + PC_W'(win_idx * VECTOR_STRIDE);
                    for (int i = 0; i < NUM_SRC; i++) begin
                        if (win_idx == PC_W'(i + 1) && !is_level[i]) begin
                            next_r.ack[i] = 1'b1;
                        end
                    end
                end
            end
            IESTK_ENTRY: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h2) begin
                    next_r.we    = 1'b1;
                    next_r.addr  = r.sp;
                    next_r.wdata = r.save_pc[7:0];
                    next_r.sp    = r.sp - 16'h0001;
                end else if (r.cnt == 4'h1) begin
                    next_r.we    = 1'b1;
                    next_r.addr  = r.sp;
                    next_r.wdata = 8'(r.save_pc >> 8);
                    next_r.sp    = r.sp - 16'h0001;
                    next_r.pc_load  = 1'b1;
                    next_r.pc_value = r.vec;
                    next_r.stall    = 1'b0;
                    next_r.state    = IESTK_IDLE;
                end
            end
            IESTK_EXIT: begin
                next_r.cnt = r.cnt - 4'h1;
                if (r.cnt == 4'h3) begin
                    next_r.rest_pc = PC_W'(mem_rdata) << 8;
                    next_r.addr    = r.addr + 16'h0001;
                end else if (r.cnt == 4'h2) begin
                    next_r.rest_pc = r.rest_pc | PC_W'(mem_rdata);
                end else if (r.cnt == 4'h1) begin
                    next_r.sp             = r.sp + 16'h0002;
                    next_r.flags[GIE_BIT] = 1'b1;
                    next_r.hold_one       = 1'b1;
                    next_r.pc_load        = 1'b1;
                    next_r.pc_value       = r.rest_pc;
                    next_r.stall          = 1'b0;
                    next_r.state          = IESTK_IDLE;
                end
            end
            default: begin
                next_r.state = IESTK_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r       <= '0;
            r.state <= IESTK_IDLE;
            r.sp    <= TOP_OF_DATA_MEMORY;
        end else begin
            r <= next_r;
        end
    end

    assign stack_pointer_high = r.sp[15:8];
    assign stack_pointer_low  = r.sp[7:0];
    assign cpu_flags_reg      = r.flags;
    assign core_control_reg   = r.ctrl;
    assign pending_flags      = sticky;
    assign irq_ack            = r.ack;
    assign seq_stall          = r.stall;
    assign mem_we             = r.we;
    assign mem_addr           = r.addr;
    assign mem_wdata          = r.wdata;
    assign pc_load            = r.pc_load;
    assign pc_value           = r.pc_value;
    assign reset_vector       = r.rst_vec;
endmodule : iestk_core

// [dv/iestk_monitor.sv]
// Checker for the interrupt entry, return and request flag timing.
`timescale 1ns/1ps
module iestk_monitor
    import iestk_pkg::*;
(
    input wire logic               clock,
    input wire logic               rst_n,
    input wire logic [NUM_SRC-1:0] event_in,
    input wire logic [NUM_SRC-1:0] is_level,
    input wire logic [NUM_SRC-1:0] irq_enable,
    input wire logic [NUM_SRC-1:0] flag_clear_wr,
    input wire logic               sleeping,
    input wire logic [3:0]         op,
    input wire logic [NUM_SRC-1:0] pending_flags,
    input wire logic [NUM_SRC-1:0] irq_ack,
    input wire logic [7:0]         cpu_flags_reg,
    input wire logic               pc_load
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_ack_one_hot: assert property (|irq_ack |-> $onehot(irq_ack))
        else $error("acknowledge names more than one source");
    chk_ack_one_cycle: assert property (|irq_ack |=> irq_ack == '0)
        else $error("acknowledge longer than one cycle");
    chk_entry_gie_off: assert property (|irq_ack |-> !cpu_flags_reg[GIE_BIT])
        else $error("global enable still set on entry");
    chk_ack_enabled: assert property ((irq_ack & ~$past(irq_enable)) == '0)
        else $error("disabled source acknowledged");
    chk_entry_time: assert property (|irq_ack && !$past(sleeping) |-> ##4 pc_load)
        else $error("entry vector not loaded in time");
    chk_wake_time: assert property (|irq_ack && $past(sleeping) |-> ##8 pc_load)
        else $error("wake entry vector not loaded in time");
    chk_cli_blocks: assert property (op == IESTK_OP_CLI |=> irq_ack == '0)
        else $error("interrupt taken after global disable");
    chk_sei_defer: assert property (op == IESTK_OP_SEI |=> (irq_ack == '0) [*2])
        else $error("interrupt taken right after global enable");
    chk_exit_time: assert property (op == IESTK_OP_IRQ_EXIT_INSTR |-> ##5 pc_load)
        else $error("return not finished in four cycles");
    chk_flag_clear: assert property ((pending_flags & $past(flag_clear_wr & ~event_in)) == '0)
        else $error("flag survived a clear write");
    chk_flag_hold: assert property ((~pending_flags & $past(event_in & ~is_level)) == '0)
        else $error("event did not set its flag");
    cover property (|irq_ack && sleeping);
    cover property (op == IESTK_OP_IRQ_EXIT_INSTR);
    cover property (|(pending_flags & ~irq_enable));
endmodule : iestk_monitor

bind iestk_core iestk_monitor i_mon (.*);

// [dv/iestk_stack_mem.sv]
// Behavioural data memory that holds the stack bytes for the core.
`timescale 1ns/1ps
module iestk_stack_mem
    import iestk_pkg::*;
(
    input  wire logic            clock,
    input  wire logic            mem_we,
    input  wire logic [SP_W-1:0] mem_addr,
    input  wire logic [7:0]      mem_wdata,
    output logic      [7:0]      mem_rdata
);
    logic [7:0] mem [0:2047];
    // Unwritten bytes hold a pattern so a stray read never looks like a saved address.
    initial for (int i = 0; i < 2048; i++) mem[i] = 8'h5a ^ 8'(i);
    // Read data follows the address in the same cycle, as the core expects.
    assign mem_rdata = mem[mem_addr[10:0]];
    always @(posedge clock) if (mem_we) mem[mem_addr[10:0]] <= mem_wdata;
endmodule : iestk_stack_mem

// [dv/tb.sv]
// Self-checking testbench for the interrupt entry and stack unit.
`timescale 1ns/1ps
module tb;
    import iestk_pkg::*;
    logic               clock = 1'b0;
    logic               rst_n = 1'b0;
    logic [NUM_SRC-1:0] event_in, level_req, is_level, irq_enable, flag_clear_wr;
    logic               instr_boundary, sleeping, sph_wr, spl_wr, flags_wr, ctrl_wr;
    logic               boot_vector_fuse, seq_stall, mem_we, pc_load;
    logic [3:0]         op;
    logic [PC_W-1:0]    return_pc, pc_value, reset_vector;
    logic [7:0]         io_wdata, flags_wdata, ctrl_wdata, mem_rdata, mem_wdata;
    logic [7:0]         stack_pointer_high, stack_pointer_low, cpu_flags_reg, core_control_reg;
    logic [NUM_SRC-1:0] pending_flags, irq_ack;
    logic [SP_W-1:0]    mem_addr;
    logic [15:0]        sp0;
    int                 fail_count = 0;
    int                 num_checks = 0;
    iestk_op_e          opt[4] = '{IESTK_OP_PUSH, IESTK_OP_POP, IESTK_OP_CALL, IESTK_OP_RET};
    logic [15:0]        dlt[4] = '{16'hffff, 16'h0001, 16'hfffe, 16'h0002};
    iestk_core i_dut (.*);
    iestk_stack_mem i_mem (.*);
    always #50 clock = ~clock;
    function automatic logic [15:0] sp();
        return {stack_pointer_high, stack_pointer_low};
    endfunction : sp
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic do_op(input iestk_op_e o);
        op <= o;
        cyc(1);
        op <= IESTK_OP_NONE;
        cyc(3);
    endtask : do_op
    task automatic io_wr(input int sel, input logic [7:0] d);
        {io_wdata, flags_wdata, ctrl_wdata} <= {3{d}};
        {sph_wr, spl_wr, flags_wr, ctrl_wr} <= 4'h8 >> sel;
        cyc(1);
        {sph_wr, spl_wr, flags_wr, ctrl_wr} <= 4'h0;
        cyc(1);
    endtask : io_wr
    // Waits for the entry stall, then times the vector load from it.
    // Level sources get no acknowledge, so the stall marks entry for every source.
    task automatic serve(input iestk_op_e o, input logic [12:0] vec, input int gap, input int src);
        int n;
        op <= o;
        cyc(1);
        op <= IESTK_OP_NONE;
        n = 0;
        while (seq_stall !== 1'b1 && n < 30) begin
            cyc(1);
            n++;
        end
        chk(seq_stall, 1'b1);
        chk(irq_ack, 16'(is_level[src] ? 0 : 1 << src));
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (pc_load !== 1'b1 && n < 30);
        chk(16'(n), 16'(gap));
        chk(seq_stall, 1'b0);
        chk(pc_value, vec);
        cyc(1);
    endtask : serve
    task automatic ret_chk();
        logic [15:0] s;
        s = sp();
        do_op(IESTK_OP_IRQ_EXIT_INSTR);
        cyc(2);
        chk(pc_load, 1'b1);
        chk(pc_value, return_pc);
        chk(sp(), s + 16'h0002);
        chk(cpu_flags_reg[GIE_BIT], 1'b1);
    endtask : ret_chk
    task automatic quiet();
        int k;
        k = 0;
        repeat (10) begin
            cyc(1);
            k += (irq_ack !== 8'h00 || seq_stall !== 1'b0);
        end
        chk(16'(k), 16'h0000);
    endtask : quiet
    initial begin
        {event_in, level_req, is_level, irq_enable, flag_clear_wr} = '0;
        {sleeping, sph_wr, spl_wr, flags_wr, ctrl_wr} = '0;
        {io_wdata, flags_wdata, ctrl_wdata} = '0;
        op = IESTK_OP_NONE;
        return_pc = 13'h0abc;
        boot_vector_fuse = 1'b1;
        instr_boundary = 1'b1;
        cyc(4);
        rst_n <= 1'b1;
        cyc(2);
        chk(sp(), TOP_OF_DATA_MEMORY);
        chk(cpu_flags_reg, 8'h00);
        chk(reset_vector, BOOT_SECTION_BASE);
        io_wr(0, 8'h04);
        io_wr(1, 8'h80);
        chk(sp(), 16'h0480);
        foreach (opt[i]) begin
            sp0 = sp();
            do_op(opt[i]);
            chk(sp(), sp0 + dlt[i]);
        end
        event_in <= 8'haa;
        cyc(1);
        event_in <= 8'h00;
        flag_clear_wr <= 8'h80;
        cyc(1);
        flag_clear_wr <= 8'h00;
        cyc(2);
        chk(pending_flags, 8'h2a);
        irq_enable <= 8'h2a;
        io_wr(2, 8'h15);
        sp0 = sp();
        serve(IESTK_OP_SEI, 13'h0004, 4, 1);
        chk(sp(), sp0 - 16'h0002);
        chk(i_mem.mem[sp0[10:0]], return_pc[7:0]);
        chk(i_mem.mem[sp0[10:0] - 11'h001], {3'h0, return_pc[12:8]});
        chk(cpu_flags_reg, 8'h15);
        chk(pending_flags, 8'h28);
        ret_chk();
        serve(IESTK_OP_NONE, 13'h0008, 4, 3);
        io_wr(3, 8'h02);
        chk(core_control_reg, 8'h02);
        irq_enable <= 8'h2b;
        event_in <= 8'h01;
        sleeping <= 1'b1;
        cyc(1);
        event_in <= 8'h00;
        ret_chk();
        serve(IESTK_OP_NONE, BOOT_SECTION_BASE + 13'h0002, 8, 0);
        sleeping <= 1'b0;
        ret_chk();
        serve(IESTK_OP_NONE, BOOT_SECTION_BASE + 13'h000c, 4, 5);
        ret_chk();
        irq_enable <= 8'hc0;
        is_level <= 8'h80;
        cyc(1);
        // The live level request meets the disable in the very same cycle.
        {event_in, level_req} <= 16'h4080;
        do_op(IESTK_OP_CLI);
        {event_in, level_req} <= 16'h0000;
        quiet();
        chk(pending_flags, 8'h40);
        flag_clear_wr <= 8'h40;
        is_level <= 8'h80;
        level_req <= 8'h80;
        cyc(1);
        {flag_clear_wr, level_req} <= 16'h0000;
        irq_enable <= 8'h80;
        do_op(IESTK_OP_SEI);
        chk(pending_flags, 8'h00);
        quiet();
        instr_boundary <= 1'b0;
        level_req <= 8'h80;
        quiet();
        instr_boundary <= 1'b1;
        serve(IESTK_OP_NONE, BOOT_SECTION_BASE + 13'h0010, 4, 7);
        conclude();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        cyc(3000);
        fail_count++;
        conclude();
    end
endmodule : tb
